/* rtl/i2csw_pkg.sv */
// Shared constants of the four-channel bus switch controller
package i2csw_pkg;
    localparam int unsigned CHAN_COUNT = 4;
    localparam logic [4:0] ADDR_FIXED = 5'h0e;   // Upper target address bits
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned BUS_KHZ_MAX = 400;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [3:0] CHAN_NONE = 4'h0;
    localparam logic [6:0] ADDR_LOW_MASK = 7'h03;
endpackage

/* rtl/i2csw_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module i2csw_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
        if (!resetn_i) begin
            meta_d = INIT;
            sync_d = INIT;
        end
    end

    always_ff @(posedge clock_i) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_o = sync_q;
endmodule

/* rtl/i2csw_top.sv */
// Four-channel bus switch: target logic, channel routing, interrupt AND
`timescale 1ns/100ps
// Operation
// [RL1] Upstream pair connects to any combination of channels per control reg
// [RL2] Lows on upstream or enabled downstream lines propagate both ways
// [RL3] Control register written over the bus; rates from static to 400 kHz
// [RL4] Power-on reset clears control register, no channel connected
// [RL5] Reset pin low resets bus state machine and deselects all channels
// [RL6] Four active-low interrupt inputs, one per downstream channel
// [RL7] Interrupt output is AND of the four active-low inputs
// [RL8] Two address pins set the low target address bits
module i2csw_top (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic por_n_i,
    input wire logic addr_sel_bit0_i,
    input wire logic addr_sel_bit1_i,
    input wire logic up_clk_i,
    output logic up_clk_o,
    output logic up_clk_oe_o,
    input wire logic up_data_i,
    output logic up_data_o,
    output logic up_data_oe_o,
    input wire logic [3:0] downstream_clk_n_i,
    output logic [3:0] downstream_clk_n_o,
    output logic [3:0] downstream_clk_n_oe_o,
    input wire logic [3:0] downstream_data_n_i,
    output logic [3:0] downstream_data_n_o,
    output logic [3:0] downstream_data_n_oe_o,
    input wire logic chan0_irq_n_i,
    input wire logic chan1_irq_n_i,
    input wire logic chan2_irq_n_i,
    input wire logic chan3_irq_n_i,
    output logic irq_n_o,
    output logic [3:0] chan_sel_o
);
    localparam int unsigned NCH = i2csw_pkg::CHAN_COUNT;

    typedef enum logic [5:0] {
        I2CSW_IDLE = 6'h01,
        I2CSW_ADDR = 6'h02,
        I2CSW_AACK = 6'h04,
        I2CSW_DATA = 6'h08,
        I2CSW_DACK = 6'h10,
        I2CSW_RDAT = 6'h20
    } i2csw_state_type;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [13:0] pins_s;
    logic up_clk_s;
    logic up_data_s;
    logic [3:0] dn_clk_s;
    logic [3:0] dn_data_s;
    logic [3:0] irq_s;
    logic rst_pin_n;

    i2csw_sync #(.WIDTH(14), .INIT(14'h3fff)) u_sync (
        .clock_i(clock_i),
        .resetn_i(por_n_i),
        .async_i({up_clk_i, up_data_i, downstream_clk_n_i,
                  downstream_data_n_i, chan3_irq_n_i, chan2_irq_n_i,
                  chan1_irq_n_i, chan0_irq_n_i}),
        .sync_o(pins_s)
    );

    assign up_clk_s = pins_s[13];
    assign up_data_s = pins_s[12];
    assign dn_clk_s = pins_s[11:8];
    assign dn_data_s = pins_s[7:4];
    assign irq_s = pins_s[3:0]; // RL6
    // Pin reset is sampled, not asynchronous, so only a low present at a clock edge clears state
    assign rst_pin_n = resetn_i;

    // ----------------------------------------------------------------
    // Bus edge and condition detection
    // ----------------------------------------------------------------
    logic clk_prev_q, clk_prev_d;
    logic dat_prev_q, dat_prev_d;
    logic clk_rise, clk_fall, start_c, stop_c;

    assign clk_rise = up_clk_s & ~clk_prev_q; // RL3
    assign clk_fall = ~up_clk_s & clk_prev_q;
    assign start_c = up_clk_s & clk_prev_q & dat_prev_q & ~up_data_s;
    assign stop_c = up_clk_s & clk_prev_q & ~dat_prev_q & up_data_s;

    // ----------------------------------------------------------------
    // Target state machine
    // ----------------------------------------------------------------
    i2csw_state_type state_q, state_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic sda_drv_q, sda_drv_d;
    logic rd_q, rd_d;
    logic [6:0] my_addr;

    // Only the address pins' low bits vary; upper bits are fixed
    assign my_addr = {i2csw_pkg::ADDR_FIXED,
                      addr_sel_bit1_i, addr_sel_bit0_i}; // RL8

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ctrl_d = ctrl_q;
        sda_drv_d = sda_drv_q;
        rd_d = rd_q;
        clk_prev_d = up_clk_s;
        dat_prev_d = up_data_s;
        if (start_c) begin
            state_d = I2CSW_ADDR;
            bit_d = i2csw_pkg::BIT_FIRST;
            // Stale byte must not match at the first clock fall after START
            shift_d = 8'h00;
            sda_drv_d = 1'b0;
        end else if (stop_c) begin
            state_d = I2CSW_IDLE;
            sda_drv_d = 1'b0;
        end else begin
            unique case (state_q)
                I2CSW_IDLE: begin
                    sda_drv_d = 1'b0;
                end
                I2CSW_ADDR, I2CSW_DATA: begin
                    if (clk_rise) begin
                        shift_d = {shift_q[6:0], up_data_s};
                        bit_d = bit_q + 3'h1;
                    end
                    if (clk_fall && bit_q == i2csw_pkg::BIT_FIRST
                        && shift_q != 8'h00 || clk_fall
                        && bit_q == i2csw_pkg::BIT_FIRST
                        && state_q == I2CSW_DATA) begin
                        if (state_q == I2CSW_ADDR) begin
                            if (shift_q[7:1] == my_addr) begin // RL8
                                state_d = I2CSW_AACK;
                                rd_d = shift_q[0];
                                sda_drv_d = 1'b1;
                            end else begin
                                state_d = I2CSW_IDLE;
                            end
                        end else begin
                            ctrl_d = shift_q[3:0]; // RL3
                            state_d = I2CSW_DACK;
                            sda_drv_d = 1'b1;
                        end
                    end
                end
                I2CSW_AACK, I2CSW_DACK: begin
                    if (clk_fall) begin
                        bit_d = i2csw_pkg::BIT_FIRST;
                        shift_d = {4'h0, ctrl_q};
                        if (rd_q) begin
                            state_d = I2CSW_RDAT;
                            sda_drv_d = ~shift_d[i2csw_pkg::BIT_LAST];
                        end else begin
                            state_d = I2CSW_DATA;
                            shift_d = 8'h00;
                            sda_drv_d = 1'b0;
                        end
                    end
                end
                I2CSW_RDAT: begin
                    // Read back: drive low for each zero bit, MSB first
                    sda_drv_d = ~shift_q[i2csw_pkg::BIT_LAST - bit_q];
                    if (clk_fall) begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == i2csw_pkg::BIT_LAST) begin
                            state_d = I2CSW_IDLE;
                            sda_drv_d = 1'b0;
                        end
                    end
                end
                default: begin
                    state_d = I2CSW_IDLE;
                end
            endcase
        end
        if (!por_n_i) begin
            ctrl_d = i2csw_pkg::CTRL_RESET; // RL4
        end
        if (!rst_pin_n || !por_n_i) begin
            state_d = I2CSW_IDLE; // RL5
            ctrl_d = i2csw_pkg::CHAN_NONE; // RL5
            sda_drv_d = 1'b0;
            bit_d = i2csw_pkg::BIT_FIRST;
            shift_d = 8'h00;
            rd_d = 1'b0;
            clk_prev_d = 1'b1;
            dat_prev_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        state_q <= state_d;
        bit_q <= bit_d;
        shift_q <= shift_d;
        ctrl_q <= ctrl_d;
        sda_drv_q <= sda_drv_d;
        rd_q <= rd_d;
        clk_prev_q <= clk_prev_d;
        dat_prev_q <= dat_prev_d;
    end

    // ----------------------------------------------------------------
    // Switch emulation and interrupt output
    // ----------------------------------------------------------------
    // Pass gates become low-wins repeaters; only lows are forwarded, and
    // a line this block drives is not fed back, avoiding latch-up loops.
    logic [3:0] dn_clk_oe_q, dn_clk_oe_d;
    logic [3:0] dn_dat_oe_q, dn_dat_oe_d;
    logic up_clk_oe_q, up_clk_oe_d;
    logic up_dat_oe_q, up_dat_oe_d;
    logic irq_q, irq_d;
    // Drive history spans the synchroniser delay: a line just released
    // still reads low for two cycles and must not be echoed back
    logic [9:0] hist1_q, hist1_d, hist2_q, hist2_d;
    logic [3:0] dn_clk_own, dn_dat_own;
    logic up_clk_own, up_dat_own;

    assign dn_clk_own = dn_clk_oe_q | hist1_q[9:6] | hist2_q[9:6];
    assign dn_dat_own = dn_dat_oe_q | hist1_q[5:2] | hist2_q[5:2];
    assign up_clk_own = up_clk_oe_q | hist1_q[1] | hist2_q[1];
    assign up_dat_own = up_dat_oe_q | hist1_q[0] | hist2_q[0];

    always_comb begin
        up_clk_oe_d = 1'b0;
        up_dat_oe_d = sda_drv_q;
        irq_d = &irq_s; // RL7
        hist1_d = {dn_clk_oe_q, dn_dat_oe_q, up_clk_oe_q, up_dat_oe_q};
        hist2_d = hist1_q;
        for (int i = 0; i < NCH; i++) begin
            dn_clk_oe_d[i] = ctrl_q[i] & ~up_clk_s & ~up_clk_own; // RL2
            dn_dat_oe_d[i] = ctrl_q[i] & ~up_data_s & ~up_dat_own;
            up_clk_oe_d = up_clk_oe_d | (ctrl_q[i] & ~dn_clk_s[i]
                          & ~dn_clk_own[i]); // RL1
            up_dat_oe_d = up_dat_oe_d | (ctrl_q[i] & ~dn_data_s[i]
                          & ~dn_dat_own[i]); // RL2
        end
        if (!rst_pin_n || !por_n_i) begin
            dn_clk_oe_d = i2csw_pkg::CHAN_NONE;
            dn_dat_oe_d = i2csw_pkg::CHAN_NONE;
            up_clk_oe_d = 1'b0;
            up_dat_oe_d = 1'b0;
            irq_d = 1'b1;
            hist1_d = 10'h000;
            hist2_d = 10'h000;
        end
    end

    always_ff @(posedge clock_i) begin
        dn_clk_oe_q <= dn_clk_oe_d;
        dn_dat_oe_q <= dn_dat_oe_d;
        up_clk_oe_q <= up_clk_oe_d;
        up_dat_oe_q <= up_dat_oe_d;
        irq_q <= irq_d;
        hist1_q <= hist1_d;
        hist2_q <= hist2_d;
    end

    assign up_clk_o = 1'b0;
    assign up_data_o = 1'b0;
    assign downstream_clk_n_o = i2csw_pkg::CHAN_NONE;
    assign downstream_data_n_o = i2csw_pkg::CHAN_NONE;
    assign up_clk_oe_o = up_clk_oe_q;
    assign up_data_oe_o = up_dat_oe_q;
    assign downstream_clk_n_oe_o = dn_clk_oe_q;
    assign downstream_data_n_oe_o = dn_dat_oe_q;
    assign irq_n_o = irq_q;
    assign chan_sel_o = ctrl_q;
endmodule

/* tb/i2csw_bus_model.sv */
// Open-drain wires of both bus sides, with pull-ups
`timescale 1ns/100ps
module i2csw_bus_model (
    input wire logic [1:0] host_pull_i,
    input wire logic [1:0] dut_up_oe_i,
    input wire logic [3:0] dev_clk_pull_i,
    input wire logic [3:0] dev_data_pull_i,
    input wire logic [3:0] dut_clk_oe_i,
    input wire logic [3:0] dut_data_oe_i,
    output logic [1:0] up_wire_o,
    output logic [3:0] clk_wire_o,
    output logic [3:0] data_wire_o
);
    // ----------------------------------------
    // Wired-AND
    // ----------------------------------------
    // A released line reads high; any party pulling low wins
    assign up_wire_o = ~(host_pull_i | dut_up_oe_i);
    assign clk_wire_o = ~(dev_clk_pull_i | dut_clk_oe_i);
    assign data_wire_o = ~(dev_data_pull_i | dut_data_oe_i);
endmodule

/* tb/i2csw_top_sva.sv */
// Port checks of the bus switch
`timescale 1ns/100ps
module i2csw_top_sva (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic por_n_i,
    input wire logic up_clk_i,
    input wire logic up_clk_oe_o,
    input wire logic up_data_oe_o,
    input wire logic [3:0] downstream_clk_n_oe_o,
    input wire logic [3:0] downstream_data_n_i,
    input wire logic [3:0] downstream_data_n_oe_o,
    input wire logic chan0_irq_n_i,
    input wire logic chan1_irq_n_i,
    input wire logic chan2_irq_n_i,
    input wire logic chan3_irq_n_i,
    input wire logic irq_n_o,
    input wire logic [3:0] chan_sel_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i || !por_n_i);
    logic quiet;
    assign quiet = chan0_irq_n_i & chan1_irq_n_i & chan2_irq_n_i
                   & chan3_irq_n_i;
    // Five cycles covers two sync flops plus the output register
    sequence s_quiet;
        quiet [*5];
    endsequence
    sequence s_busy;
        !quiet [*5];
    endsequence
    sequence s_up_low;
        (!up_clk_i && chan_sel_o[0] && !up_clk_oe_o) [*4];
    endsequence
    sequence s_dn_low;
        (!downstream_data_n_i[0] && chan_sel_o[0]
            && !downstream_data_n_oe_o[0]) [*4];
    endsequence
    property p_irq_high;
        s_quiet |-> irq_n_o;
    endproperty
    property p_irq_low;
        s_busy |-> !irq_n_o;
    endproperty
    property p_rst_clear;
        disable iff (1'h0) !resetn_i |=> chan_sel_o == 4'h0
            && downstream_data_n_oe_o == 4'h0 && !up_data_oe_o;
    endproperty
    property p_por_clear;
        disable iff (1'h0) !por_n_i |=> chan_sel_o == 4'h0
            && downstream_clk_n_oe_o == 4'h0;
    endproperty
    property p_sel_gate;
        (downstream_data_n_oe_o & ~chan_sel_o & ~$past(chan_sel_o)) == 4'h0;
    endproperty
    property p_sel_edge;
        $changed(chan_sel_o) |-> !up_clk_i;
    endproperty
    property p_up_to_dn;
        s_up_low |-> downstream_clk_n_oe_o[0];
    endproperty
    property p_dn_to_up;
        s_dn_low |-> up_data_oe_o;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("irq low with no source");
    a_irq_low: assert property (p_irq_low)
        else $error("irq high with a source low");
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset pin left a channel on");
    a_por_clear: assert property (p_por_clear)
        else $error("power-on reset left a channel on");
    a_sel_gate: assert property (p_sel_gate)
        else $error("drive on a deselected channel");
    a_sel_edge: assert property (p_sel_edge)
        else $error("select changed with clock high");
    a_up_to_dn: assert property (p_up_to_dn)
        else $error("clock low not passed down");
    a_dn_to_up: assert property (p_dn_to_up)
        else $error("data low not passed up");
endmodule
bind i2csw_top i2csw_top_sva u_sva (
    .clock_i, .resetn_i, .por_n_i, .up_clk_i, .up_clk_oe_o, .up_data_oe_o,
    .downstream_clk_n_oe_o, .downstream_data_n_i, .downstream_data_n_oe_o,
    .chan0_irq_n_i, .chan1_irq_n_i, .chan2_irq_n_i, .chan3_irq_n_i,
    .irq_n_o, .chan_sel_o
);

/* tb/i2csw_top_test.sv */
// Self-checking bench of the bus switch
`timescale 1ns/100ps
module i2csw_top_test;
    logic clock_i = 1'h0;
    logic resetn = 1'h0;
    logic por_n = 1'h0;
    logic addr_sel_bit0 = 1'h1;
    logic addr_sel_bit1 = 1'h0;
    logic [1:0] hp = 2'h0;
    logic [3:0] ddc = 4'h0;
    logic [3:0] ddp = 4'h0;
    logic [3:0] irq = 4'hf;
    logic ack;
    wire [1:0] upw;
    wire [3:0] dcw, ddw, dco, ddo, sel;
    wire uco, udo, irq_o;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    // ----------------------------------------
    // Design and wires
    // ----------------------------------------
    i2csw_top dut (.clock_i(clock_i), .resetn_i(resetn), .por_n_i(por_n),
        .addr_sel_bit0_i(addr_sel_bit0), .addr_sel_bit1_i(addr_sel_bit1),
        .up_clk_i(upw[1]),
        .up_clk_o(), .up_clk_oe_o(uco), .up_data_i(upw[0]), .up_data_o(),
        .up_data_oe_o(udo), .downstream_clk_n_i(dcw), .downstream_clk_n_o(),
        .downstream_clk_n_oe_o(dco), .downstream_data_n_i(ddw),
        .downstream_data_n_o(), .downstream_data_n_oe_o(ddo),
        .chan0_irq_n_i(irq[0]), .chan1_irq_n_i(irq[1]),
        .chan2_irq_n_i(irq[2]), .chan3_irq_n_i(irq[3]),
        .irq_n_o(irq_o), .chan_sel_o(sel));
    i2csw_bus_model bus (.host_pull_i(hp), .dut_up_oe_i({uco, udo}),
        .dev_clk_pull_i(ddc), .dev_data_pull_i(ddp), .dut_clk_oe_i(dco),
        .dut_data_oe_i(ddo), .up_wire_o(upw), .clk_wire_o(dcw),
        .data_wire_o(ddw));
    always #2.5 clock_i = ~clock_i;
    // Run is a few thousand cycles; the ceiling only catches a hang
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic w(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One 80 ns bit, clock low on entry and exit
    task automatic bitx(input logic b);
        hp[0] <= !b;
        w(4);
        hp[1] <= 1'h0;
        w(6);
        #1 ack = !upw[0];
        w(2);
        hp[1] <= 1'h1;
        w(4);
    endtask
    task automatic byte_out(input logic [7:0] v, output logic a);
        for (int i = 7; i >= 0; i--) bitx(v[i]);
        bitx(1'h1);
        a = ack;
    endtask
    task automatic xfer(input logic [6:0] ad, input logic [7:0] d,
                        input logic ea);
        logic a;
        hp[0] <= 1'h1;
        w(8);
        hp[1] <= 1'h1;
        w(4);
        byte_out({ad, 1'h0}, a);
        chk({3'h0, a}, {3'h0, ea});
        if (a) begin
            byte_out(d, a);
            chk({3'h0, a}, 4'h1);
        end
        hp[0] <= 1'h1;
        w(4);
        hp[1] <= 1'h0;
        w(8);
        hp[0] <= 1'h0;
        w(8);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sel();
        logic [7:0] v[4] = '{8'h01, 8'h06, 8'hfa, 8'h0f};
        chk(sel, 4'h0);
        chk({3'h0, irq_o}, 4'h1);
        foreach (v[i]) begin
            xfer(7'h39, v[i], 1'h1);
            chk(sel, v[i][3:0]);
        end
        xfer(7'h38, 8'h03, 1'h0);
        chk(sel, 4'hf);
        addr_sel_bit1 <= 1'h1;
        addr_sel_bit0 <= 1'h0;
        w(4);
        xfer(7'h3a, 8'h05, 1'h1);
        chk(sel, 4'h5);
        $display("select done");
    endtask
    // Read back of the control register, host NACKs the byte
    task automatic t_read();
        logic a;
        logic [7:0] rv;
        hp[0] <= 1'h1;
        w(8);
        hp[1] <= 1'h1;
        w(4);
        byte_out({7'h3a, 1'h1}, a);
        chk({3'h0, a}, 4'h1);
        for (int i = 7; i >= 0; i--) begin
            bitx(1'h1);
            rv[i] = !ack;
        end
        bitx(1'h1);
        chk(rv[3:0], 4'h5);
        chk(rv[7:4], 4'h0);
        hp[0] <= 1'h1;
        w(4);
        hp[1] <= 1'h0;
        w(8);
        hp[0] <= 1'h0;
        w(8);
        $display("read done");
    endtask
    task automatic t_route();
        hp[1] <= 1'h1;
        w(6);
        chk(dco, 4'h5);
        hp[1] <= 1'h0;
        w(6);
        chk(dco, 4'h0);
        chk({3'h0, uco}, 4'h0);
        hp[0] <= 1'h1;
        w(6);
        chk(ddo, 4'h5);
        hp[0] <= 1'h0;
        w(6);
        chk({3'h0, udo}, 4'h0);
        ddc <= 4'h2;
        w(6);
        chk({3'h0, uco}, 4'h0);
        ddc <= 4'h4;
        w(6);
        chk({3'h0, uco}, 4'h1);
        ddc <= 4'h0;
        w(6);
        chk({3'h0, uco}, 4'h0);
        ddp <= 4'h2;
        w(6);
        chk({3'h0, udo}, 4'h0);
        ddp <= 4'h4;
        w(6);
        chk({3'h0, udo}, 4'h1);
        ddp <= 4'h0;
        w(8);
        $display("route done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < 4; i++) begin
            irq <= ~(4'h1 << i);
            w(6);
            chk({3'h0, irq_o}, 4'h0);
        end
        irq <= 4'hf;
        w(6);
        chk({3'h0, irq_o}, 4'h1);
        $display("irq done");
    endtask
    // A stuck channel is cleared by the reset pin, then power-on reset
    task automatic t_stuck();
        ddp <= 4'h1;
        w(6);
        chk({3'h0, udo}, 4'h1);
        resetn <= 1'h0;
        w(4);
        chk(sel, 4'h0);
        chk(ddo | dco, 4'h0);
        resetn <= 1'h1;
        w(6);
        chk({3'h0, udo}, 4'h0);
        ddp <= 4'h0;
        w(4);
        xfer(7'h3a, 8'h0c, 1'h1);
        por_n <= 1'h0;
        w(4);
        por_n <= 1'h1;
        w(4);
        chk(sel, 4'h0);
        $display("reset done");
    endtask
    task automatic results();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        w(4);
        resetn <= 1'h1;
        por_n <= 1'h1;
        w(4);
        t_sel();
        t_read();
        t_route();
        t_irq();
        t_stuck();
        results();
    end
endmodule
